// [verilog/srs_params.svh]
/*
 * Constants of the supply reset sequencer: timing counts, flag positions,
 * reset values.
 * Assumes inclusion by bare name from design files only.
 */
`ifndef SRS_PARAMS_SVH
`define SRS_PARAMS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SRS_CLK_PERIOD_PS   5000
`define SRS_POR_TIME_NS     100000
`define SRS_POR_CYCLES      ((`SRS_POR_TIME_NS * 1000) / `SRS_CLK_PERIOD_PS)
`define SRS_POR_EXT_CYCLES  65536
`define SRS_MSS_TIME_NS     2000
`define SRS_MSS_TICKS       ((`SRS_MSS_TIME_NS * 1000 + `SRS_CLK_PERIOD_PS - 1) / `SRS_CLK_PERIOD_PS)

// ----------------------------------------------------------------
// Diagnosis flag positions
// ----------------------------------------------------------------
`define SRS_DIAG_RST        0
`define SRS_DIAG_PUMP_UV    1
`define SRS_DIAG_PUMP_WARN  2
`define SRS_DIAG_WIDTH      3
`define SRS_DIAG_RESET_VAL  3'h0

`endif

// [verilog/srs_pkg.sv]
/*
 * Types of the supply reset sequencer.
 * Assumes nothing of its surroundings.
 */
package srs_pkg;
	typedef enum logic [2:0] {
		SRS_SLEEP,
		SRS_HOLD,
		SRS_POR_WAIT,
		SRS_RUN,
		SRS_WD_TRIP
	} srs_state_t;
endpackage

// [verilog/srs_delay_counter.sv]
/*
 * Power-on delay counter with a registered done flag.
 * Assumes run is a level: counting runs while run is high, clears when low.
 */
`timescale 1ns/10ps
module srs_delay_counter #(
	parameter int WIDTH = 17
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	// Control
	input  wire logic             run,
	input  wire logic [WIDTH-1:0] limit,
	// Status
	output logic                  done
);
	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] count_nxt;
	logic             done_r;
	logic             done_nxt;

	// Count up while running, stop one below the limit
	always_comb begin
		count_nxt = count_r;
		done_nxt  = done_r;
		if (!run) begin
			count_nxt = '0;
			done_nxt  = 1'b0;
		end else if (count_r >= limit - WIDTH'(1)) begin
			done_nxt = 1'b1;
		end else begin
			count_nxt = count_r + WIDTH'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_r <= '0;
			done_r  <= 1'b0;
		end else begin
			count_r <= count_nxt;
			done_r  <= done_nxt;
		end
	end

	assign done = done_r;
endmodule

// [verilog/supply_reset_sequencer.sv]
/*
 * Reset, sleep and supply supervision of a two-channel solenoid driver.
 * Assumes comparator and pin inputs are synchronous to ref_clk; clkTick is
 * one pulse per rising edge of the external clock, seen in ref_clk domain.
 */
//Contract
//- Any core supply undervoltage holds reset
//- Enabled watchdog resets on missing clock
//- Release after supplies good plus delay
//- No SPI accepted before delay completes
//- Delay starts after reset pin rises
//- Set reset flag on leaving reset
//- Diagnosis access clears reset flag
//- Pump undervoltage disables outputs, flags
//- Pump warning sets separate flag
//- Warning band keeps outputs running
//- Any core supply low means sleep
//- Sleep exits automatically when supplies good
//- Sleep exit reruns full delay
//- Enable low stops channels, masked fault
//- Load undervoltage stops only that channel
//- Reset pin low: reset, fault, no SPI
//- Watchdog trip answers with version read
`timescale 1ns/10ps
`include "srs_params.svh"
module supply_reset_sequencer
	import srs_pkg::*;
#(
	parameter int CHANNELS   = 2,
	parameter int POR_CYCLES = `SRS_POR_EXT_CYCLES,
	parameter int MSS_TICKS  = `SRS_MSS_TICKS
) (
	// Clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       reset_n,
	// Supply comparators, high means below threshold, batteryOv high means above
	input  wire logic                       digitalUv,
	input  wire logic                       analogUv,
	input  wire logic                       analogRefUv,
	input  wire logic                       pumpUv,
	input  wire logic                       pumpWarn,
	input  wire logic                       batteryOv,
	input  wire logic [CHANNELS-1:0]        loadSupplyUv,
	// Host pins
	input  wire logic                       externalResetN,
	input  wire logic                       enablePin,
	input  wire logic                       clkTick,
	// Configuration
	input  wire logic                       clockWatchdogEnable,
	input  wire logic                       enableFaultMask,
	input  wire logic [CHANNELS-1:0]        channelFaultMask,
	input  wire logic                       channelFaultPending,
	// Diagnosis register access
	input  wire logic                       diagAccess,
	// Outputs
	output logic                            logicResetN,
	output logic                            sleepMode,
	output logic                            spiEnable,
	output logic                            spiForceVersion,
	output logic [CHANNELS-1:0]             channelEnable,
	output logic [`SRS_DIAG_WIDTH-1:0]      diagFlags,
	output logic                            faultOutN,
	output logic                            faultOutOe
);
	// ----------------------------------------------------------------
	// Supervision state
	// ----------------------------------------------------------------
	srs_state_t               state_r;
	srs_state_t               state_nxt;
	logic [31:0]              mssCount_r;
	logic [31:0]              mssCount_nxt;
	logic                     delayDone;
	logic                     coreUv;
	logic                     clockMissing;

	// Any of the three core supplies low
	assign coreUv = digitalUv | analogUv | analogRefUv;
	assign clockMissing = (mssCount_r >= 32'(MSS_TICKS));

	// Decode of the released state; shared by the flag and output logic
	function automatic logic isRun(input srs_state_t s);
		return (s == SRS_RUN);
	endfunction

	srs_delay_counter #(
		.WIDTH (17)
	) u_delay (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.run     (state_r == SRS_POR_WAIT),
		.limit   (17'(POR_CYCLES)),
		.done    (delayDone)
	);

	// Next state of the supervisor
	always_comb begin
		state_nxt      = state_r;
		mssCount_nxt   = clkTick ? 32'h0 : (clockMissing ? mssCount_r : mssCount_r + 32'h1);
		case (state_r)
			SRS_SLEEP: begin
				if (!coreUv)
					state_nxt = SRS_HOLD;
			end
			SRS_HOLD: begin
				if (externalResetN && clkTick)
					state_nxt = SRS_POR_WAIT;
			end
			SRS_POR_WAIT: begin
				if (delayDone)
					state_nxt = SRS_RUN;
			end
			SRS_RUN: begin
				if (clockWatchdogEnable && clockMissing)
					state_nxt = SRS_WD_TRIP;
			end
			SRS_WD_TRIP: begin
				// Only external reset or power loss leaves the trip
				state_nxt = SRS_WD_TRIP;
			end
			default: state_nxt = SRS_SLEEP;
		endcase
		if (coreUv)
			state_nxt = SRS_SLEEP;
		else if (!externalResetN)
			state_nxt = SRS_HOLD;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r      <= SRS_SLEEP;
			mssCount_r   <= 32'h0;
		end else begin
			state_r      <= state_nxt;
			mssCount_r   <= mssCount_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Diagnosis flags and outputs
	// ----------------------------------------------------------------
	logic [`SRS_DIAG_WIDTH-1:0] diag_r;
	logic [`SRS_DIAG_WIDTH-1:0] diag_nxt;
	logic                       running;
	logic [CHANNELS-1:0]        chanEn_nxt;
	logic                       fault_nxt;
	logic                       leavingReset;
	logic                       logicResetN_nxt;
	logic                       sleepMode_nxt;
	logic                       spiEnable_nxt;
	logic                       spiForceVersion_nxt;
	logic [CHANNELS-1:0]        channelEnable_nxt;
	logic                       faultOutN_nxt;

	assign running      = isRun(state_r);
	assign leavingReset = (state_r == SRS_POR_WAIT) && isRun(state_nxt);

	// Flags: hardware set wins over access clear
	always_comb begin
		diag_nxt = diag_r;
		if (diagAccess && running)
			diag_nxt[`SRS_DIAG_RST] = 1'b0;
		if (leavingReset)
			diag_nxt[`SRS_DIAG_RST] = 1'b1;
		diag_nxt[`SRS_DIAG_PUMP_UV]   = running & pumpUv;
		diag_nxt[`SRS_DIAG_PUMP_WARN] = running & pumpWarn;
	end

	// Per-channel enables
	always_comb begin
		chanEn_nxt = '0;
		for (int i = 0; i < CHANNELS; i++) begin
			chanEn_nxt[i] = running & clockWatchdogEnable & enablePin & ~pumpUv
				& ~batteryOv & ~loadSupplyUv[i];
		end
	end

	// Fault pin, pulled low on any active condition
	always_comb begin
		fault_nxt = running & ~clockMissing & ~pumpUv & ~batteryOv & ~channelFaultPending
			& ~(~enablePin & enableFaultMask) & ~|(loadSupplyUv & channelFaultMask);
	end

	// Output next values from the next state, so every pin leaves a flop
	always_comb begin
		logicResetN_nxt     = isRun(state_nxt);
		sleepMode_nxt       = (state_nxt == SRS_SLEEP);
		spiEnable_nxt       = isRun(state_nxt) | (state_nxt == SRS_WD_TRIP);
		spiForceVersion_nxt = (state_nxt == SRS_WD_TRIP);
		channelEnable_nxt   = chanEn_nxt & {CHANNELS{isRun(state_nxt)}};
		// Fault pin lags release by a cycle, as fault_nxt looks at the old state
		faultOutN_nxt       = fault_nxt & isRun(state_nxt);
	end

	// Output and flag registers
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			diag_r          <= `SRS_DIAG_RESET_VAL;
			logicResetN     <= 1'b0;
			sleepMode       <= 1'b1;
			spiEnable       <= 1'b0;
			spiForceVersion <= 1'b0;
			channelEnable   <= '0;
			faultOutN       <= 1'b0;
			faultOutOe      <= 1'b1;
		end else begin
			diag_r          <= diag_nxt;
			logicResetN     <= logicResetN_nxt;
			sleepMode       <= sleepMode_nxt;
			spiEnable       <= spiEnable_nxt;
			spiForceVersion <= spiForceVersion_nxt;
			channelEnable   <= channelEnable_nxt;
			faultOutN       <= faultOutN_nxt;
			// Open drain: drive only while pulling low
			faultOutOe      <= ~faultOutN_nxt;
		end
	end

	assign diagFlags = diag_r;
endmodule

// [testbench/srs_assertions.sv]
/* Port checker of the supply reset sequencer.
   Assumes binding onto supply_reset_sequencer with its port names. */
`timescale 1ns/10ps
module srs_assertions #(
	parameter int CHANNELS = 2
) (
	// Clock and reset
	input wire logic                ref_clk,
	input wire logic                reset_n,
	// Watched inputs
	input wire logic                digitalUv,
	input wire logic                analogUv,
	input wire logic                analogRefUv,
	input wire logic                pumpUv,
	input wire logic [CHANNELS-1:0] loadSupplyUv,
	input wire logic                externalResetN,
	input wire logic                enablePin,
	input wire logic                diagAccess,
	input wire logic                channelFaultPending,
	// Watched outputs
	input wire logic                logicResetN,
	input wire logic                sleepMode,
	input wire logic                spiEnable,
	input wire logic [CHANNELS-1:0] channelEnable,
	input wire logic [2:0]          diagFlags,
	input wire logic                faultOutN
);
	// Any core supply low
	wire logic uvAny = digitalUv | analogUv | analogRefUv;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	property p_uvRst; uvAny |=> !logicResetN; endproperty
	a_uvRst: assert property (p_uvRst) else $error("uv without reset");
	property p_uvSlp; uvAny |=> sleepMode; endproperty
	a_uvSlp: assert property (p_uvSlp) else $error("uv without sleep");
	property p_pin; !externalResetN |=> !logicResetN && !spiEnable && !faultOutN; endproperty
	a_pin: assert property (p_pin) else $error("pin low not held");
	property p_rel; $rose(logicResetN) |-> diagFlags[0] && !$past(uvAny); endproperty
	a_rel: assert property (p_rel) else $error("bad release");
	property p_clr; diagAccess && logicResetN && $past(logicResetN) |=> !diagFlags[0]; endproperty
	a_clr: assert property (p_clr) else $error("flag not cleared");
	property p_pump; pumpUv |=> channelEnable == '0; endproperty
	a_pump: assert property (p_pump) else $error("pump uv outputs on");
	property p_en; !enablePin |=> channelEnable == '0; endproperty
	a_en: assert property (p_en) else $error("enable low outputs on");
	property p_ld; loadSupplyUv[0] |=> !channelEnable[0]; endproperty
	a_ld: assert property (p_ld) else $error("load uv channel on");
	property p_flt; faultOutN |-> $past(externalResetN && !channelFaultPending); endproperty
	a_flt: assert property (p_flt) else $error("fault released early");
endmodule
bind supply_reset_sequencer srs_assertions #(.CHANNELS(CHANNELS)) chk (
	.ref_clk(ref_clk), .reset_n(reset_n), .digitalUv(digitalUv), .analogUv(analogUv),
	.analogRefUv(analogRefUv), .pumpUv(pumpUv), .loadSupplyUv(loadSupplyUv),
	.externalResetN(externalResetN), .enablePin(enablePin), .diagAccess(diagAccess),
	.channelFaultPending(channelFaultPending), .logicResetN(logicResetN), .sleepMode(sleepMode),
	.spiEnable(spiEnable), .channelEnable(channelEnable), .diagFlags(diagFlags), .faultOutN(faultOutN)
);

// [testbench/srs_host.sv]
/* Host clock model: one tick every fourth cycle while running.
   Assumes ref_clk from the bench. */
`timescale 1ns/10ps
module srs_host (
	// Clock and control
	input  wire logic ref_clk,
	input  wire logic tickOn,
	// External clock edges
	output logic      clkTick
);
	logic [1:0] phase_r = 2'h0;
	// Stopped host clock gives no ticks at all
	always @(negedge ref_clk) begin
		phase_r <= phase_r + 2'h1;
		clkTick <= tickOn && phase_r == 2'h0;
	end
endmodule

// [testbench/supply_reset_sequencer_tb.sv]
/* Self-checking bench of the supply reset sequencer.
   Assumes short delay and watchdog counts set at the instance. */
`timescale 1ns/10ps
module supply_reset_sequencer_tb;
	logic ref_clk = 1'b0, reset_n = 1'b0, digitalUv = 1'b0, analogUv = 1'b0, analogRefUv = 1'b0;
	logic pumpUv = 1'b0, pumpWarn = 1'b0, batteryOv = 1'b0, externalResetN = 1'b0, enablePin = 1'b1;
	logic clkTick, clockWatchdogEnable = 1'b1, enableFaultMask = 1'b1, channelFaultPending = 1'b0;
	logic diagAccess = 1'b0, tickOn = 1'b1, logicResetN, sleepMode, spiEnable, spiForceVersion;
	logic faultOutN, faultOutOe;
	logic [1:0] loadSupplyUv = 2'h0, channelFaultMask = 2'h0, channelEnable;
	logic [2:0] diagFlags;
	int badCount = 0, checksDone = 0;
	supply_reset_sequencer #(.POR_CYCLES(16), .MSS_TICKS(20)) dut (
		.ref_clk(ref_clk), .reset_n(reset_n), .digitalUv(digitalUv), .analogUv(analogUv),
		.analogRefUv(analogRefUv), .pumpUv(pumpUv), .pumpWarn(pumpWarn), .batteryOv(batteryOv),
		.loadSupplyUv(loadSupplyUv), .externalResetN(externalResetN), .enablePin(enablePin),
		.clkTick(clkTick), .clockWatchdogEnable(clockWatchdogEnable), .enableFaultMask(enableFaultMask),
		.channelFaultMask(channelFaultMask), .channelFaultPending(channelFaultPending),
		.diagAccess(diagAccess), .logicResetN(logicResetN), .sleepMode(sleepMode), .spiEnable(spiEnable),
		.spiForceVersion(spiForceVersion), .channelEnable(channelEnable), .diagFlags(diagFlags),
		.faultOutN(faultOutN), .faultOutOe(faultOutOe)
	);
	srs_host host (.ref_clk(ref_clk), .tickOn(tickOn), .clkTick(clkTick));
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checksDone++;
		if (g !== e) begin
			badCount++;
			$display("Error at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// Bounded wait so a stuck reset cannot hang
	task automatic waitRun(output int n);
		n = 0;
		while (logicResetN !== 1'b1 && n < 300) begin
			cyc(1);
			n++;
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic tPor;
		int n;
		cyc(4);
		chk(faultOutN, 8'h0);
		chk(faultOutOe, 8'h1);
		chk(spiEnable, 8'h0);
		externalResetN = 1'b1;
		waitRun(n);
		chk(n >= 16, 8'h1);
		chk(spiEnable, 8'h1);
		chk(diagFlags[0], 8'h1);
		// Fault pin is released one cycle after the logic
		cyc(1);
		chk(faultOutN, 8'h1);
		chk(faultOutOe, 8'h0);
		diagAccess = 1'b1;
		cyc(1);
		diagAccess = 1'b0;
		cyc(1);
		chk(diagFlags[0], 8'h0);
		$display("power-on test done");
	endtask
	task automatic tChan;
		enablePin = 1'b0;
		cyc(2);
		chk(channelEnable, 8'h0);
		chk(faultOutN, 8'h0);
		enableFaultMask = 1'b0;
		cyc(2);
		chk(channelEnable, 8'h0);
		chk(faultOutN, 8'h1);
		enableFaultMask = 1'b1;
		enablePin = 1'b1;
		loadSupplyUv = 2'h1;
		cyc(2);
		chk(channelEnable, 8'h2);
		chk(faultOutN, 8'h1);
		channelFaultMask = 2'h1;
		cyc(2);
		chk(channelEnable, 8'h2);
		chk(faultOutN, 8'h0);
		channelFaultMask = 2'h0;
		loadSupplyUv = 2'h0;
		channelFaultPending = 1'b1;
		cyc(2);
		chk(faultOutN, 8'h0);
		channelFaultPending = 1'b0;
		batteryOv = 1'b1;
		cyc(2);
		chk(channelEnable, 8'h0);
		chk(faultOutN, 8'h0);
		batteryOv = 1'b0;
		cyc(2);
		chk(faultOutN, 8'h1);
		$display("channel test done");
	endtask
	task automatic tPump;
		pumpWarn = 1'b1;
		cyc(2);
		chk(diagFlags[2], 8'h1);
		chk(channelEnable, 8'h3);
		pumpUv = 1'b1;
		cyc(2);
		chk(channelEnable, 8'h0);
		chk(diagFlags[1], 8'h1);
		pumpUv = 1'b0;
		pumpWarn = 1'b0;
		$display("pump test done");
	endtask
	task automatic tSleep;
		int n;
		analogUv = 1'b1;
		cyc(2);
		chk(sleepMode, 8'h1);
		chk(logicResetN, 8'h0);
		analogUv = 1'b0;
		waitRun(n);
		chk(n >= 16, 8'h1);
		chk(sleepMode, 8'h0);
		chk(diagFlags[0], 8'h1);
		$display("sleep test done");
	endtask
	task automatic tWdog;
		int n;
		clockWatchdogEnable = 1'b0;
		tickOn = 1'b0;
		cyc(40);
		chk(logicResetN, 8'h1);
		clockWatchdogEnable = 1'b1;
		cyc(40);
		chk(logicResetN, 8'h0);
		chk(spiForceVersion, 8'h1);
		tickOn = 1'b1;
		externalResetN = 1'b0;
		cyc(4);
		externalResetN = 1'b1;
		waitRun(n);
		chk(logicResetN, 8'h1);
		$display("watchdog test done");
	endtask
	task automatic stopTest;
		$display("checks %0d mismatches %0d", checksDone, badCount);
		if (badCount == 0 && checksDone > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Main sequence, then a watchdog well past its length
	initial begin
		cyc(3);
		reset_n = 1'b1;
		tPor;
		tChan;
		tPump;
		tSleep;
		tWdog;
		stopTest;
	end
	initial begin
		#20000;
		badCount++;
		stopTest;
	end
endmodule
